/* File: rtl/dprc_pkg.sv */
// constants and helper functions for the dual-port ram port control block
package dprc_pkg;

    // ------------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------------
    localparam int DPRC_AW    = 10;
    localparam int DPRC_DW    = 18;
    localparam int DPRC_DEPTH = 1024;

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    localparam int          DPRC_AXI_AW   = 4;
    localparam int          DPRC_AXI_DW   = 32;
    localparam logic [1:0]  DPRC_CTRL_IDX = 2'h0;
    localparam logic [1:0]  DPRC_STAT_IDX = 2'h1;
    localparam logic [3:0]  DPRC_CTRL_OFS = 4'h0;
    localparam logic [3:0]  DPRC_STAT_OFS = 4'h4;
    localparam logic [1:0]  DPRC_RESP_OK  = 2'h0;
    localparam logic [1:0]  DPRC_RESP_ERR = 2'h2;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int         DPRC_CTRL_W    = 6;
    localparam int         DPRC_FT_A      = 0;
    localparam int         DPRC_FT_B      = 1;
    localparam int         DPRC_PIPE_A    = 2;
    localparam int         DPRC_PIPE_B    = 3;
    localparam int         DPRC_TWO_PORT  = 4;
    localparam int         DPRC_RUN       = 5;
    localparam logic [5:0] DPRC_CTRL_RST  = 6'h00;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int DPRC_ST_ZERO_A = 0;
    localparam int DPRC_ST_ZERO_B = 1;
    localparam int DPRC_ST_BUSY_A = 2;
    localparam int DPRC_ST_BUSY_B = 3;

    // word index of a byte address on the register bus
    function automatic logic [1:0] dprc_word(input logic [DPRC_AXI_AW-1:0] addr);
        return addr[3:2];
    endfunction

    // a port writes when selected with write enable high at the edge
    function automatic logic dprc_is_write(input logic sel, input logic wen);
        return sel & wen;
    endfunction

endpackage

/* File: rtl/dprc_port.sv */
// output data path of one ram port: core output stage and pipeline register
`timescale 1ns/1ps
module dprc_port import dprc_pkg::*; (
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    input  wire logic               port_rst_low,
    input  wire logic               sel,
    input  wire logic               wen,
    input  wire logic               dout_en,
    input  wire logic               feed_through,
    input  wire logic               pipe_en,
    input  wire logic [DPRC_DW-1:0] din,
    input  wire logic [DPRC_DW-1:0] rd_data,
    output logic      [DPRC_DW-1:0] dout
);

    logic [DPRC_DW-1:0] core_reg;
    logic [DPRC_DW-1:0] core_next;
    logic [DPRC_DW-1:0] pipe_reg;
    logic [DPRC_DW-1:0] pipe_next;

    // ------------------------------------------------------------------
    // core output stage
    // ------------------------------------------------------------------
    // reset clears, deselect clears, read loads, feed-through write shows din,
    // simple write keeps the last read value (zero after reset)
    assign core_next = !port_rst_low ? '0 :
                       !sel          ? '0 :
                       !wen          ? rd_data :
                       feed_through  ? din : core_reg;

    // pipeline stage ignores select; only its own enable and reset matter
    assign pipe_next = !port_rst_low ? '0 :
                       dout_en       ? core_reg : pipe_reg;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            core_reg <= '0;
            pipe_reg <= '0;
            dout     <= '0;
        end else begin
            core_reg <= core_next;
            pipe_reg <= pipe_next;
            dout     <= pipe_en ? pipe_next : core_next;
        end
    end

endmodule

/* File: rtl/dprc_axil.sv */
// axi4-lite slave holding the control register and returning status
`timescale 1ns/1ps
module dprc_axil import dprc_pkg::*; (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic [DPRC_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [DPRC_AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic      [1:0]             s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [DPRC_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic      [DPRC_AXI_DW-1:0] s_axi_rdata,
    output logic      [1:0]             s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [DPRC_AXI_DW-1:0] status,
    output logic      [DPRC_CTRL_W-1:0] ctrl
);

    logic                   aw_full_reg;
    logic                   w_full_reg;
    logic [DPRC_AXI_AW-1:0] waddr_reg;
    logic [DPRC_AXI_DW-1:0] wdata_reg;
    logic                   wstrb0_reg;

    // ------------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------------
    wire                   aw_take   = s_axi_awvalid & s_axi_awready;
    wire                   w_take    = s_axi_wvalid & s_axi_wready;
    wire                   have_aw   = aw_full_reg | aw_take;
    wire                   have_w    = w_full_reg | w_take;
    wire                   do_write  = have_aw & have_w;
    wire [DPRC_AXI_AW-1:0] wr_addr   = aw_take ? s_axi_awaddr : waddr_reg;
    wire [DPRC_AXI_DW-1:0] wr_data   = w_take ? s_axi_wdata : wdata_reg;
    wire                   wr_strb0  = w_take ? s_axi_wstrb[0] : wstrb0_reg;
    wire                   wr_ctrl   = dprc_word(wr_addr) == DPRC_CTRL_IDX;
    wire                   wr_mapped = wr_ctrl | (dprc_word(wr_addr) == DPRC_STAT_IDX);
    wire                   aw_full_next = have_aw & !do_write;
    wire                   w_full_next  = have_w & !do_write;
    wire                   bvalid_next  = do_write | (s_axi_bvalid & !s_axi_bready);
    // mode bits are frozen while running; only the run bit may be cleared
    wire [DPRC_CTRL_W-1:0] ctrl_wr   = ctrl[DPRC_RUN] ?
                                       {wr_data[DPRC_RUN], ctrl[DPRC_RUN-1:0]} :
                                       wr_data[DPRC_CTRL_W-1:0];

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    wire                   ar_take     = s_axi_arvalid & s_axi_arready;
    wire                   rvalid_next = ar_take | (s_axi_rvalid & !s_axi_rready);
    wire [1:0]             rd_idx      = dprc_word(s_axi_araddr);
    wire [DPRC_AXI_DW-1:0] rd_word     =
        (rd_idx == DPRC_CTRL_IDX) ? {{(DPRC_AXI_DW-DPRC_CTRL_W){1'b0}}, ctrl} :
        (rd_idx == DPRC_STAT_IDX) ? status : '0;
    wire [1:0]             rd_resp     =
        (rd_idx == DPRC_CTRL_IDX || rd_idx == DPRC_STAT_IDX) ? DPRC_RESP_OK : DPRC_RESP_ERR;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            waddr_reg     <= '0;
            wdata_reg     <= '0;
            wstrb0_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= DPRC_RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= DPRC_RESP_OK;
            ctrl          <= DPRC_CTRL_RST;
        end else begin
            aw_full_reg   <= aw_full_next;
            w_full_reg    <= w_full_next;
            waddr_reg     <= wr_addr;
            wdata_reg     <= wr_data;
            wstrb0_reg    <= wr_strb0;
            s_axi_awready <= !aw_full_next & !bvalid_next;
            s_axi_wready  <= !w_full_next & !bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (do_write) begin
                s_axi_bresp <= wr_mapped ? DPRC_RESP_OK : DPRC_RESP_ERR;
            end
            if (do_write && wr_ctrl && wr_strb0) begin
                ctrl <= ctrl_wr;
            end
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_resp;
            end
        end
    end

endmodule

/* File: rtl/dprc_top.sv */
// dual-port ram with per-port write modes, output reset, block select and pipeline
//
// Contract
// - feed-through write without pipeline shows written data at that write's edge
// - feed-through write with pipeline shows written data one clock later
// - two-port mode offers no feed-through write
// - simple write keeps last read value; new data seen only on later read
// - port reset is active low; held high in normal operation
// - reset during a read forces the port output to zero
// - after reset the output stays zero until a read or feed-through write
// - select high lets the port read and write (here only while the control register run bit is set)
// - select low: no access, output driven to zero until next read
// - pipeline register ignores select; select effect appears one clock later
// - both ports may read one address together and get stored data
// - read on one port, write on other, same address: stored, read corrupt
// - two writes to one address: equal data stored, differing data undetermined
// - pipelined read appears next cycle, flow-through read at the read edge
// - each port's output register has a load enable
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module dprc_top import dprc_pkg::*; (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   first_port_select,
    input  wire logic                   first_port_async_reset_low,
    input  wire logic                   first_port_wen,
    input  wire logic                   first_port_dout_en,
    input  wire logic [DPRC_AW-1:0]     first_port_addr,
    input  wire logic [DPRC_DW-1:0]     first_port_din,
    output logic      [DPRC_DW-1:0]     first_port_dout,
    input  wire logic                   second_port_select,
    input  wire logic                   second_port_async_reset_low,
    input  wire logic                   second_port_wen,
    input  wire logic                   second_port_dout_en,
    input  wire logic [DPRC_AW-1:0]     second_port_addr,
    input  wire logic [DPRC_DW-1:0]     second_port_din,
    output logic      [DPRC_DW-1:0]     second_port_dout,
    input  wire logic [DPRC_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [DPRC_AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic      [1:0]             s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [DPRC_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic      [DPRC_AXI_DW-1:0] s_axi_rdata,
    output logic      [1:0]             s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    logic [DPRC_DW-1:0]     mem [DPRC_DEPTH];
    logic [DPRC_CTRL_W-1:0] ctrl;
    logic [DPRC_AXI_DW-1:0] status_reg;

    // ------------------------------------------------------------------
    // effective port controls
    // ------------------------------------------------------------------
    wire run      = ctrl[DPRC_RUN];
    wire two_port = ctrl[DPRC_TWO_PORT];
    // in two-port mode the first port only reads and the second only writes
    wire sel_a    = first_port_select & run;
    wire wen_a    = first_port_wen & !two_port;
    wire sel_b    = second_port_select & run & (!two_port | second_port_wen);
    wire wen_b    = second_port_wen;
    wire ft_a     = ctrl[DPRC_FT_A] & !two_port;
    wire ft_b     = ctrl[DPRC_FT_B] & !two_port;
    wire pipe_a   = ctrl[DPRC_PIPE_A];
    wire pipe_b   = ctrl[DPRC_PIPE_B];
    wire wr_a     = dprc_is_write(sel_a, wen_a);
    wire wr_b     = dprc_is_write(sel_b, wen_b);
    wire same_adr = first_port_addr == second_port_addr;

    wire [DPRC_DW-1:0] rd_a = mem[first_port_addr];
    wire [DPRC_DW-1:0] rd_b = mem[second_port_addr];

    // ------------------------------------------------------------------
    // memory array
    // ------------------------------------------------------------------
    // a read colliding with a write returns the old word, which is as good as
    // any garbage; on a write-write clash the first port's data is kept
    always_ff @(posedge clk_sys) begin
        if (wr_a) begin
            mem[first_port_addr] <= first_port_din;
        end
        if (wr_b && !(wr_a && same_adr)) begin
            mem[second_port_addr] <= second_port_din;
        end
    end

    // ------------------------------------------------------------------
    // port output paths
    // ------------------------------------------------------------------
    dprc_port u_port_a (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .port_rst_low (first_port_async_reset_low),
        .sel          (sel_a),
        .wen          (wen_a),
        .dout_en      (first_port_dout_en),
        .feed_through (ft_a),
        .pipe_en      (pipe_a),
        .din          (first_port_din),
        .rd_data      (rd_a),
        .dout         (first_port_dout)
    );

    dprc_port u_port_b (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .port_rst_low (second_port_async_reset_low),
        .sel          (sel_b),
        .wen          (wen_b),
        .dout_en      (second_port_dout_en),
        .feed_through (ft_b),
        .pipe_en      (pipe_b),
        .din          (second_port_din),
        .rd_data      (rd_b),
        .dout         (second_port_dout)
    );

    // ------------------------------------------------------------------
    // status and register bus
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            status_reg <= '0;
        end else begin
            status_reg                 <= '0;
            status_reg[DPRC_ST_ZERO_A] <= first_port_dout == '0;
            status_reg[DPRC_ST_ZERO_B] <= second_port_dout == '0;
            status_reg[DPRC_ST_BUSY_A] <= sel_a;
            status_reg[DPRC_ST_BUSY_B] <= sel_b;
        end
    end

    dprc_axil u_axil (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .status        (status_reg),
        .ctrl          (ctrl)
    );

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    wire rst_hi_a = first_port_async_reset_low;
    wire rst_hi_b = second_port_async_reset_low;

    a_ft_flow_write: assert property (
        (wr_a && ft_a && !pipe_a && rst_hi_a && $stable(ctrl)) |=> first_port_dout == $past(first_port_din))
        else $error("feed-through write not shown at the write edge");

    a_ft_pipe_write: assert property (
        (wr_a && ft_a && pipe_a && rst_hi_a) ##1 (first_port_dout_en && rst_hi_a && pipe_a)
        |=> first_port_dout == $past(first_port_din, 2))
        else $error("pipelined feed-through write not shown one clock later");

    a_two_port_noft: assert property (
        (two_port && wr_b && !pipe_b && rst_hi_b && $stable(ctrl)) |=> $stable(second_port_dout))
        else $error("second port showed write data in two-port mode");

    a_simple_hold: assert property (
        (wr_b && !ft_b && !pipe_b && rst_hi_b && $stable(ctrl)) |=> $stable(second_port_dout))
        else $error("simple write changed the output");

    a_reset_clears: assert property (
        !second_port_async_reset_low |=> second_port_dout == '0)
        else $error("port reset did not clear the output");

    a_desel_zero: assert property (
        (!sel_a && !pipe_a && rst_hi_a && $stable(ctrl)) |=> first_port_dout == '0)
        else $error("deselected port output not zero");

    a_pipe_desel: assert property (
        (!sel_a && rst_hi_a && pipe_a) ##1 (first_port_dout_en && rst_hi_a && pipe_a)
        |=> first_port_dout == '0)
        else $error("deselect not seen one pipeline clock later");

    a_flow_read: assert property (
        (sel_a && !wen_a && !pipe_a && rst_hi_a && !(wr_b && same_adr) && $stable(ctrl))
        |=> first_port_dout == $past(rd_a))
        else $error("flow-through read data wrong");

    a_dout_en_hold: assert property (
        (pipe_a && $past(pipe_a) && !first_port_dout_en && rst_hi_a) |=> $stable(first_port_dout))
        else $error("output register loaded without its enable");

    a_ctrl_static: assert property (
        ($past(run) && run) |-> $stable(ctrl))
        else $error("mode bits changed while running");

    c_ft_write:    cover property (wr_a && ft_a && !pipe_a);
    c_pipe_read:   cover property (sel_a && !wen_a && pipe_a ##1 first_port_dout_en);
    c_dual_read:   cover property (sel_a && !wen_a && sel_b && !wen_b && same_adr);
    c_port_reset:  cover property (!second_port_async_reset_low ##1 second_port_async_reset_low);

endmodule

/* File: sim/dprc_user.sv */
// fabric user logic model that drives one ram port
`timescale 1ns/1ps
module dprc_user import dprc_pkg::*; (
    input  wire logic               clk_sys,
    output logic                    sel,
    output logic                    wen,
    output logic                    rst_low,
    output logic                    dout_en,
    output logic      [DPRC_AW-1:0] addr,
    output logic      [DPRC_DW-1:0] din
);
    initial begin
        sel = 1'b0;
        wen = 1'b0;
        rst_low = 1'b1;
        dout_en = 1'b1;
        addr = '0;
        din = '0;
    end
    // lines change after an edge and hold to the next one
    task automatic op(input logic w, input logic [DPRC_AW-1:0] a, input logic [DPRC_DW-1:0] d);
        sel <= 1'b1;
        wen <= w;
        addr <= a;
        din <= d;
        @(posedge clk_sys);
        sel <= 1'b0;
        wen <= ~w;
        addr <= ~a; // released lines must not keep the last value
        din <= ~d;
        #1;
    endtask
    // issued alongside a read only; a write in that cycle would still be stored
    task automatic rst_pulse();
        rst_low <= 1'b0;
        @(posedge clk_sys);
        rst_low <= 1'b1;
        #1;
    endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the dual-port ram port control block
`timescale 1ns/1ps
module tb_top import dprc_pkg::*; ;
    logic               clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               as, aw, ar, ae, bs, bw, br, be;
    logic [DPRC_AW-1:0] aa, ba;
    logic [DPRC_DW-1:0] ad, bd, aq, bq;
    int                 fails, comparisons;
    dprc_user u_a (.clk_sys, .sel(as), .wen(aw), .rst_low(ar), .dout_en(ae), .addr(aa), .din(ad));
    dprc_user u_b (.clk_sys, .sel(bs), .wen(bw), .rst_low(br), .dout_en(be), .addr(ba), .din(bd));
    dprc_top dut (.clk_sys, .rstn, .first_port_select(as), .first_port_async_reset_low(ar),
        .first_port_wen(aw), .first_port_dout_en(ae), .first_port_addr(aa), .first_port_din(ad),
        .first_port_dout(aq), .second_port_select(bs), .second_port_async_reset_low(br),
        .second_port_wen(bw), .second_port_dout_en(be), .second_port_addr(ba), .second_port_din(bd),
        .second_port_dout(bq), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------------
    // checks and bus cycles
    // ------------------------------------------------------------------
    task automatic cmp_d(input logic [DPRC_DW-1:0] g, input logic [DPRC_DW-1:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t ram data %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t bus value %h want %h", $time, g, e);
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        cmp_b({30'h0, s_axi_bresp}, {30'h0, er});
        #1;
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp_b(s_axi_rdata, e);
        cmp_b({30'h0, s_axi_rresp}, {30'h0, er});
        #1;
    endtask
    // modes only change with run cleared, so clear it first
    task automatic cfg(input logic [5:0] m);
        axw(DPRC_CTRL_OFS, 32'h0, DPRC_RESP_OK);
        axw(DPRC_CTRL_OFS, {26'h0, m}, DPRC_RESP_OK);
        @(posedge clk_sys);
        #1;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_bus();
        axr(DPRC_CTRL_OFS, 32'h0, DPRC_RESP_OK);
        axr(4'h8, 32'h0, DPRC_RESP_ERR);
        axw(4'hc, 32'h1, DPRC_RESP_ERR);
        axw(DPRC_STAT_OFS, 32'hf, DPRC_RESP_OK);
        axr(DPRC_STAT_OFS, 32'h3, DPRC_RESP_OK);
    endtask
    task automatic t_ft_nopipe();
        cfg(6'h21);
        u_a.op(1'b1, 10'h005, 18'h2a5c3);
        cmp_d(aq, 18'h2a5c3);
        // both ports read the same address together here
        fork
            u_a.op(1'b0, 10'h005, 18'h0);
            u_b.op(1'b0, 10'h005, 18'h0);
        join
        cmp_d(aq, 18'h2a5c3);
        cmp_d(bq, 18'h2a5c3);
        @(posedge clk_sys);
        #1;
        cmp_d(aq, 18'h0);
    endtask
    task automatic t_simple();
        u_b.op(1'b0, 10'h005, 18'h0);
        u_b.op(1'b1, 10'h006, 18'h15a3c);
        cmp_d(bq, 18'h2a5c3);
        u_b.op(1'b0, 10'h006, 18'h0);
        cmp_d(bq, 18'h15a3c);
    endtask
    task automatic t_port_reset();
        fork
            u_b.op(1'b0, 10'h005, 18'h0);
            u_b.rst_pulse();
        join
        cmp_d(bq, 18'h0);
        u_b.op(1'b1, 10'h007, 18'h3c0f1);
        cmp_d(bq, 18'h0);
        u_b.op(1'b0, 10'h007, 18'h0);
        cmp_d(bq, 18'h3c0f1);
    endtask
    task automatic t_pipe();
        cfg(6'h2f);
        axw(DPRC_CTRL_OFS, 32'h20, DPRC_RESP_OK);
        axr(DPRC_CTRL_OFS, 32'h2f, DPRC_RESP_OK);
        fork
            u_a.op(1'b1, 10'h009, 18'h0f0f0);
            u_b.op(1'b1, 10'h00a, 18'h30c3c);
        join
        cmp_d(aq, 18'h0);
        cmp_d(bq, 18'h0);
        @(posedge clk_sys);
        #1;
        cmp_d(aq, 18'h0f0f0);
        cmp_d(bq, 18'h30c3c);
        @(posedge clk_sys);
        #1;
        cmp_d(aq, 18'h0);
        cmp_d(bq, 18'h0);
        u_a.dout_en <= 1'b0;
        u_a.op(1'b0, 10'h009, 18'h0);
        @(posedge clk_sys);
        #1;
        cmp_d(aq, 18'h0);
        u_a.dout_en <= 1'b1;
    endtask
    task automatic t_two_port();
        cfg(6'h33);
        u_b.op(1'b1, 10'h008, 18'h1e2d4);
        cmp_d(bq, 18'h0);
        u_a.op(1'b0, 10'h008, 18'h0);
        cmp_d(aq, 18'h1e2d4);
    endtask
    task automatic end_of_test();
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the whole run needs well under a hundred cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        end_of_test();
    end
    initial begin
        fails = 0;
        comparisons = 0;
        rstn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        t_bus();
        t_ft_nopipe();
        t_simple();
        t_port_reset();
        t_pipe();
        t_two_port();
        end_of_test();
    end
endmodule
